// File: rtl/dock_defines.svh
// constants for the docking capture and interlock logic
`ifndef DOCK_DEFINES_SVH
`define DOCK_DEFINES_SVH
`define CLK_HZ 10_000_000
`define DAMPER_DELAY_S 5
`define DAMPER_DELAY_CYC (`DAMPER_DELAY_S * `CLK_HZ)
`define DEBOUNCE_CYC 16
`define SR_CAPTURE 0
`define SR_DAMPER 1
`define SR_CAPLOST 2
`define SR_POWER 3
`define IRQ_BITS 4
`define ADR_STATUS 4'h0
`define ADR_IRQ_STAT 4'h1
`define ADR_IRQ_MASK 4'h2
`define ADR_CONTROL 4'h3
`define CTRL_FIX_INHIBIT 0
`define BUS_RESET 32'h0000_0000
`endif

// File: rtl/dock_pkg.sv
// types for the docking capture and interlock logic
package dock_pkg;
  typedef enum logic [3:0] {
    PWR_OFF = 4'b0001,
    PWR_LOGIC = 4'b0010,
    PWR_DRIVE = 4'b0100,
    PWR_ON = 4'b1000
  } pwr_state_t;

  typedef struct packed {
    logic ring_out;
    logic ring_in;
    logic ring_stop;
    logic undock;
    logic hooks_open;
    logic hooks_close;
    logic latches_open;
    logic fixers_off;
    logic inhibit_release;
    logic power_on;
    logic power_off;
  } buttons_t;

  typedef struct packed {
    logic [5:0] short_c;
    logic [5:0] long_c;
    logic [2:0] logic_bus;
    logic ring_retract_auto;
  } sensors_t;

  typedef struct packed {
    logic ring_out;
    logic ring_in;
    logic ring_stop;
    logic undock;
    logic hooks_open;
    logic hooks_close;
    logic latches_open;
  } commands_t;
endpackage

// File: rtl/docking_sequence_controller.sv
// capture detection, manual interlock, fixer/damper and power sequencing
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dock_defines.svh"
module docking_sequence_controller
  import dock_pkg::*;
#(
  parameter int DAMPER_CYC = `DAMPER_DELAY_CYC,
  parameter int DEB_CYC = `DEBOUNCE_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire buttons_t BUTTONS,
  input wire sensors_t SENSORS,
  output commands_t RING_HOOK_LATCH_CMD,
  output logic LOGIC_POWER_EN,
  output logic DRIVE_POWER_EN,
  output logic CAPTURE_BUS_EN,
  output logic MANUAL_BUS_EN,
  output logic FIXERS_ON,
  output logic DAMPERS_ON,
  output logic LAMP_CAPTURE,
  output logic LAMP_POWER,
  output logic LAMP_MANUAL,
  output logic LAMP_DAMPERS,
  output logic LAMP_FIXERS,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  output logic IRQ
);
  localparam int NB = $bits(buttons_t);
  localparam int NS = $bits(sensors_t);

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning

  buttons_t btn;
  sensors_t sen;
  logic [NB+NS-1:0] filt_out;

  input_filter #(
    .WIDTH(NB + NS),
    .COUNT(DEB_CYC)
  ) u_filter (
    .clk(CLK_SYS),
    .rst(RST),
    .raw({BUTTONS, SENSORS}),
    .clean(filt_out)
  );

  assign btn = buttons_t'(filt_out[NB+NS-1:NS]);
  assign sen = sensors_t'(filt_out[NS-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    pwr_state_t pwr;
    logic captured;
    logic manual_bus;
    logic dampers;
    logic [31:0] damp_cnt;
    logic fix_suppress;
    logic ring_manual;
    logic power_on_q;
    logic [`IRQ_BITS-1:0] irq_stat;
    logic [`IRQ_BITS-1:0] irq_mask;
    logic [31:0] control;
    logic ack;
    logic [31:0] rdata;
    commands_t cmd;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic group_a;
  logic group_b;
  logic long_any;
  logic bus_lost;
  logic capture_cond;
  logic powered;
  logic fixer_request;
  logic bus_req;
  logic [`IRQ_BITS-1:0] events;
  logic [3:0] word;

  always_comb begin
    // group a takes contacts 0..2, group b 3..5, one per sensor each
    group_a = &sen.short_c[2:0];
    group_b = &sen.short_c[5:3];
    long_any = |sen.long_c;
    capture_cond = (group_a | group_b) & long_any;
    // two or more of three logic buses missing
    bus_lost = (~sen.logic_bus[0] & ~sen.logic_bus[1]) |
               (~sen.logic_bus[0] & ~sen.logic_bus[2]) |
               (~sen.logic_bus[1] & ~sen.logic_bus[2]);
    powered = (st.pwr == PWR_ON);
    bus_req = WB_CYC_I & WB_STB_I;
    word = WB_ADR_I[5:2];
  end

  always_comb begin
    next_st = st;
    events = '0;
    fixer_request = 1'b0;
    next_st.power_on_q = btn.power_on;

    // power-up chain: logic latch, then drive latch, then on
    case (st.pwr)
      PWR_OFF: begin
        if (btn.power_on & ~st.power_on_q) begin
          next_st.pwr = PWR_LOGIC;
        end
      end
      PWR_LOGIC: begin
        next_st.pwr = PWR_DRIVE;
      end
      PWR_DRIVE: begin
        next_st.pwr = PWR_ON;
        events[`SR_POWER] = 1'b1;
      end
      PWR_ON: begin
        next_st.pwr = PWR_ON;
      end
      default: begin
        next_st.pwr = PWR_OFF;
      end
    endcase
    if (btn.power_off) begin
      next_st.pwr = PWR_OFF;
      next_st.manual_bus = 1'b0;
    end

    // held capture loop; only three causes may break it
    if (btn.power_off | bus_lost) begin
      if (st.captured) begin
        events[`SR_CAPLOST] = 1'b1;
      end
      next_st.captured = 1'b0;
    end else if (st.captured & ~long_any) begin
      next_st.captured = 1'b0;
      events[`SR_CAPLOST] = 1'b1;
    end else if (~st.captured & capture_cond & powered) begin
      next_st.captured = 1'b1;
      events[`SR_CAPTURE] = 1'b1;
    end

    if (powered & btn.inhibit_release) begin
      next_st.manual_bus = 1'b1;
    end

    // dampers: count from the moment the loop closes
    if (~st.captured) begin
      next_st.damp_cnt = '0;
      next_st.dampers = 1'b0;
    end else if (btn.power_on & st.dampers) begin
      next_st.dampers = 1'b0;
    end else if (st.damp_cnt == 32'(DAMPER_CYC - 1)) begin
      if (st.damp_cnt != 32'hFFFF_FFFF) begin
        next_st.dampers = 1'b1;
        events[`SR_DAMPER] = 1'b1;
        next_st.damp_cnt = 32'hFFFF_FFFF;
      end
    end else if (st.damp_cnt != 32'hFFFF_FFFF) begin
      next_st.damp_cnt = st.damp_cnt + 32'h0000_0001;
    end

    // commands go out registered, one cycle late, while powered; ring_out, undock, hooks_open, latches_open also need manual_bus
    next_st.cmd = '0;
    if (powered) begin
      next_st.cmd.ring_out = btn.ring_out & st.manual_bus;
      next_st.cmd.undock = btn.undock & st.manual_bus;
      next_st.cmd.hooks_open = btn.hooks_open & st.manual_bus;
      next_st.cmd.latches_open = btn.latches_open & st.manual_bus;
      next_st.cmd.ring_in = btn.ring_in;
      next_st.cmd.ring_stop = btn.ring_stop;
      next_st.cmd.hooks_close = btn.hooks_close;
    end

    // manual ring drive stays latched until stop or loss of power, since drive relays latch
    if (~powered | btn.ring_stop) begin
      next_st.ring_manual = 1'b0;
    end else if (next_st.cmd.ring_out | next_st.cmd.ring_in) begin
      next_st.ring_manual = 1'b1;
    end

    fixer_request = sen.ring_retract_auto | st.ring_manual;
    if (btn.fixers_off | st.control[`CTRL_FIX_INHIBIT]) begin
      next_st.fix_suppress = 1'b1;
    end else if (~fixer_request) begin
      next_st.fix_suppress = 1'b0;
    end

    // wishbone slave: one registered ack the cycle after the strobe, then drop
    next_st.ack = bus_req & ~st.ack;
    if (bus_req & ~st.ack) begin
      if (word == `ADR_STATUS) begin
        next_st.rdata = {24'h00_0000, st.pwr, st.fix_suppress,
                         st.dampers, st.manual_bus, st.captured};
      end else if (word == `ADR_IRQ_STAT) begin
        next_st.rdata = 32'(st.irq_stat);
      end else if (word == `ADR_IRQ_MASK) begin
        next_st.rdata = 32'(st.irq_mask);
      end else if (word == `ADR_CONTROL) begin
        next_st.rdata = st.control;
      end else begin
        next_st.rdata = `BUS_RESET;
      end
    end

    // sticky status: a set in the clearing cycle wins
    next_st.irq_stat = st.irq_stat | events;
    // writes land on the edge at which the master samples ack high
    if (bus_req & st.ack & WB_WE_I & WB_SEL_I[0]) begin
      if (word == `ADR_IRQ_STAT) begin
        next_st.irq_stat = (st.irq_stat & ~WB_DAT_I[`IRQ_BITS-1:0]) | events;
      end else if (word == `ADR_IRQ_MASK) begin
        next_st.irq_mask = WB_DAT_I[`IRQ_BITS-1:0];
      end else if (word == `ADR_CONTROL) begin
        next_st.control = {31'h0000_0000, WB_DAT_I[`CTRL_FIX_INHIBIT]};
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st <= '0;
      st.pwr <= PWR_OFF;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign RING_HOOK_LATCH_CMD = st.cmd;
  assign LOGIC_POWER_EN = (st.pwr != PWR_OFF);
  assign DRIVE_POWER_EN = (st.pwr == PWR_DRIVE) | powered;
  assign CAPTURE_BUS_EN = st.captured;
  assign MANUAL_BUS_EN = st.manual_bus;
  assign FIXERS_ON = powered & (sen.ring_retract_auto | st.ring_manual) &
                     ~st.fix_suppress;
  assign DAMPERS_ON = st.dampers;
  assign LAMP_CAPTURE = st.captured;
  assign LAMP_POWER = powered;
  assign LAMP_MANUAL = st.manual_bus;
  assign LAMP_DAMPERS = st.dampers;
  assign LAMP_FIXERS = FIXERS_ON;
  assign WB_DAT_O = st.rdata;
  assign WB_ACK_O = st.ack;
  assign IRQ = |(st.irq_stat & st.irq_mask);
endmodule
`default_nettype wire

// File: rtl/input_filter.sv
// synchroniser and debounce filter, one per input bit
`timescale 1ns/10ps
`default_nettype none
`include "dock_defines.svh"
module input_filter #(
  parameter int WIDTH = 8,
  parameter int COUNT = `DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0][7:0] cnt;
  } flt_state_t;

  flt_state_t st;
  flt_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    for (int i = 0; i < WIDTH; i++) begin
      // a new level must hold for COUNT cycles before it is passed on
      if (st.s2[i] == st.out[i]) begin
        next_st.cnt[i] = 8'h00;
      end else if (st.cnt[i] == 8'(COUNT - 1)) begin
        next_st.out[i] = st.s2[i];
        next_st.cnt[i] = 8'h00;
      end else begin
        next_st.cnt[i] = st.cnt[i] + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clean = st.out;
endmodule
`default_nettype wire

// File: verif/dock_checker.sv
// port assertions for the docking sequence controller
`timescale 1ns/10ps
`default_nettype none
module dock_checker
  import dock_pkg::*;
#(
  parameter int DAMPER_CYC = 20
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire buttons_t BUTTONS,
  input wire sensors_t SENSORS,
  input wire commands_t RING_HOOK_LATCH_CMD,
  input wire logic LOGIC_POWER_EN,
  input wire logic DRIVE_POWER_EN,
  input wire logic CAPTURE_BUS_EN,
  input wire logic MANUAL_BUS_EN,
  input wire logic FIXERS_ON,
  input wire logic DAMPERS_ON,
  input wire logic LAMP_CAPTURE,
  input wire logic LAMP_MANUAL,
  input wire logic LAMP_DAMPERS
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  int cap_cnt, set_age, clr_age;
  logic [2:0] b;
  logic set_c, clr_c;
  assign b = SENSORS.logic_bus;
  assign set_c = (&SENSORS.short_c[2:0] | &SENSORS.short_c[5:3])
    & |SENSORS.long_c;
  assign clr_c = BUTTONS.power_off | ~|SENSORS.long_c
    | ~(b[0] & b[1] | b[0] & b[2] | b[1] & b[2]);
  // ages saturate so a long quiet spell cannot wrap
  always_ff @(posedge CLK_SYS) begin
    cap_cnt <= CAPTURE_BUS_EN ? cap_cnt + 1 : 0;
    set_age <= set_c ? 0 : set_age + int'(set_age < 99);
    clr_age <= clr_c ? 0 : clr_age + int'(clr_age < 99);
  end
  a_lamp_mirror: assert property (
    LAMP_CAPTURE == CAPTURE_BUS_EN && LAMP_MANUAL == MANUAL_BUS_EN
    && LAMP_DAMPERS == DAMPERS_ON) else $error("lamp differs from state");
  a_capture_cause: assert property (
    $rose(CAPTURE_BUS_EN) |-> set_age < 12) else $error("capture no cause");
  a_capture_clear: assert property (
    $fell(CAPTURE_BUS_EN) |-> clr_age < 12) else $error("capture lost");
  a_damper_delay: assert property (
    $rose(DAMPERS_ON) |-> cap_cnt + 1 >= DAMPER_CYC
    && cap_cnt <= DAMPER_CYC + 1) else $error("damper delay wrong");
  a_damper_off: assert property (
    $rose(BUTTONS.power_on) && DAMPERS_ON |-> ##[1:12] !DAMPERS_ON)
    else $error("dampers stay on");
  a_manual_gate: assert property (
    |(RING_HOOK_LATCH_CMD & 7'h4d) |-> MANUAL_BUS_EN)
    else $error("gated command without bus");
  a_fixer_suppress: assert property (
    BUTTONS.fixers_off [*8] |-> !FIXERS_ON) else $error("fixers on");
  a_power_chain: assert property (
    $rose(LOGIC_POWER_EN) |=> DRIVE_POWER_EN) else $error("chain stall");
endmodule
bind docking_sequence_controller dock_checker #(.DAMPER_CYC(DAMPER_CYC))
  i_dock_checker (.CLK_SYS, .RST, .BUTTONS, .SENSORS, .RING_HOOK_LATCH_CMD,
  .LOGIC_POWER_EN, .DRIVE_POWER_EN, .CAPTURE_BUS_EN, .MANUAL_BUS_EN,
  .FIXERS_ON, .DAMPERS_ON, .LAMP_CAPTURE, .LAMP_MANUAL, .LAMP_DAMPERS);
`default_nettype wire

// File: verif/docking_capture_interlock_logic_tb.sv
// self-checking bench for the docking capture and interlock logic
`timescale 1ns/10ps
`default_nettype none
module docking_capture_interlock_logic_tb
  import dock_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  buttons_t btn_req = '0;
  sensors_t sen_req = 16'h000e;
  buttons_t buttons;
  sensors_t sensors;
  commands_t cmd;
  logic log_en, drv_en, cap_en, man_en, fix_on, damp_on, irq, ack, l_pwr;
  logic l_fix;
  logic [31:0] adr = '0, wdat = '0, rdat, q;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  int errors = 0, n_compared = 0, cycles = 0;
  always #50 clk = ~clk;
  panel_model i_panel_model (.clk(clk), .btn_req(btn_req),
    .sen_req(sen_req), .buttons(buttons), .sensors(sensors));
  docking_sequence_controller #(.DAMPER_CYC(20), .DEB_CYC(2))
    i_docking_sequence_controller (.CLK_SYS(clk), .RST(rst),
    .BUTTONS(buttons), .SENSORS(sensors), .RING_HOOK_LATCH_CMD(cmd),
    .LOGIC_POWER_EN(log_en), .DRIVE_POWER_EN(drv_en),
    .CAPTURE_BUS_EN(cap_en), .MANUAL_BUS_EN(man_en), .FIXERS_ON(fix_on),
    .DAMPERS_ON(damp_on), .LAMP_CAPTURE(), .LAMP_POWER(l_pwr),
    .LAMP_MANUAL(), .LAMP_DAMPERS(), .LAMP_FIXERS(l_fix), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hf),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .IRQ(irq));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic hold(input buttons_t m);
    btn_req <= btn_req | m;
    tick(10);
  endtask
  task automatic rel(input buttons_t m);
    btn_req <= btn_req & ~m;
    tick(10);
  endtask
  // hangs are left to the cycle ceiling
  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    tick(2);
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power;
    wb(32'h0, 1'b0, 32'h0);
    chk("status", 32'h10, q);
    wb(32'h10, 1'b1, 32'h1);
    wb(32'h10, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    hold(11'h002);
    chk("drive", 1, drv_en & log_en & l_pwr);
    rel(11'h002);
    wb(32'h0, 1'b0, 32'h0);
    chk("pwr", 32'h80, q & 32'hf0);
    wb(32'h8, 1'b1, 32'h8);
    chk("irq", 1, irq);
    wb(32'h8, 1'b1, 32'h0);
    chk("irq", 0, irq);
    wb(32'h8, 1'b1, 32'h8);
    wb(32'h4, 1'b1, 32'h8);
    chk("irq", 0, irq);
    wb(32'h8, 1'b1, 32'h0);
    $display("t_power done");
  endtask
  task automatic t_cmds(input logic [6:0] gate);
    for (int i = 0; i < 7; i++) begin
      hold(11'h010 << i);
      chk("cmd", 32'(gate & (7'h01 << i)), 32'(cmd));
      rel(11'h010 << i);
    end
    hold(11'h100);
    rel(11'h100);
    $display("t_cmds done");
  endtask
  task automatic t_fixers;
    hold(11'h200);
    chk("fix", 3, {fix_on, l_fix});
    rel(11'h200);
    hold(11'h008);
    rel(11'h008);
    chk("fix", 0, {fix_on, l_fix});
    hold(11'h100);
    rel(11'h100);
    sen_req.ring_retract_auto <= 1'b1;
    tick(10);
    chk("fix", 3, {fix_on, l_fix});
    wb(32'hc, 1'b1, 32'h1);
    chk("fix", 0, {fix_on, l_fix});
    wb(32'hc, 1'b1, 32'h0);
    sen_req.ring_retract_auto <= 1'b0;
    tick(10);
    hold(11'h004);
    chk("man", 1, man_en);
    rel(11'h004);
    $display("t_fixers done");
  endtask
  task automatic cap(input logic [5:0] s, input logic [5:0] l, input logic e);
    sen_req.short_c <= s;
    sen_req.long_c <= l;
    tick(10);
    chk("cap", e, cap_en);
  endtask
  task automatic t_capture;
    cap(6'h03, 6'h01, 1'b0);
    cap(6'h38, 6'h00, 1'b0);
    cap(6'h38, 6'h20, 1'b1);
    chk("damp", 0, damp_on);
    tick(25);
    chk("damp", 1, damp_on);
    hold(11'h002);
    chk("damp", 0, damp_on);
    rel(11'h002);
    cap(6'h00, 6'h20, 1'b1);
    cap(6'h00, 6'h00, 1'b0);
    cap(6'h07, 6'h01, 1'b1);
    sen_req.logic_bus <= 3'b011;
    cap(6'h07, 6'h01, 1'b1);
    sen_req.logic_bus <= 3'b001;
    cap(6'h07, 6'h01, 1'b0);
    sen_req.logic_bus <= 3'b111;
    cap(6'h07, 6'h01, 1'b1);
    hold(11'h001);
    chk("cap", 0, cap_en | log_en | man_en);
    rel(11'h001);
    $display("t_capture done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      $display("[ERR] cycles expected below 20000 seen %0d", cycles);
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_power();
    t_cmds(7'h32);
    t_fixers();
    t_cmds(7'h7f);
    t_capture();
    final_report();
  end
endmodule
`default_nettype wire

// File: verif/panel_model.sv
// crew panel and contact model presenting requested levels
`timescale 1ns/10ps
`default_nettype none
module panel_model
  import dock_pkg::*;
(
  input wire logic clk,
  input wire buttons_t btn_req,
  input wire sensors_t sen_req,
  output buttons_t buttons,
  output sensors_t sensors
);
  // one stage of lag, as a panel wire through a relay would show
  always @(posedge clk) begin
    buttons <= btn_req;
    sensors <= sen_req;
  end
endmodule
`default_nettype wire
